/* File: tb/sfr_space_and_stack_pointer_test.sv */
/* Bench for ssp_sfr_stack driving the core side through one task.
   Assumes the peripheral model answers in the same cycle. */
`default_nettype none
module sfr_space_and_stack_pointer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ssp_pkg::*;
    logic clk = 0, rst = 1, ce = 1, push = 0, pop = 0;
    logic [7:0] pd = 8'h00, erd, rd, ptr;
    logic rv, er;
    ssp_req_t req = '0;
    ssp_ext_t ext;
    int bad_count = 0, total_checks = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    ssp_sfr_stack u_dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce),
        .i_push(push), .i_push_data(pd), .i_pop(pop), .i_req(req),
        .o_rdata(rd), .o_rvalid(rv), .o_err(er),
        .o_stack_top_pointer(ptr), .o_ext(ext), .i_ext_rdata(erd));
    ssp_periph_model u_per (.i_ref_clk(clk), .i_ext(ext), .o_rdata(erd));
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One access, k = {push, pop, req}, m = {write, indirect, bit}
    task automatic op(input logic [2:0] k, input logic [2:0] m,
                      input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        push <= k[2];
        pop <= k[1];
        pd <= d;
        req <= {k[0], m, a, d};
        @(posedge clk);
        push <= 1'b0;
        pop <= 1'b0;
        req <= '0;
        @(negedge clk);
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 500) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(ptr, 8'h07);
        chk({7'h00, rv}, 8'h00);
        op(3'b100, 3'b000, 8'h00, 8'ha1);
        op(3'b100, 3'b000, 8'h00, 8'hb2);
        chk(ptr, 8'h09);
        op(3'b001, 3'b000, 8'h08, 8'h00);
        chk(rd, 8'ha1);
        op(3'b010, 3'b000, 8'h00, 8'h00);
        chk(rd, 8'hb2);
        chk({7'h00, rv}, 8'h01);
        chk(ptr, 8'h08);
        $display("test push and pop done");
        op(3'b001, 3'b100, 8'h81, 8'hff);
        op(3'b100, 3'b000, 8'h00, 8'hc3);
        op(3'b001, 3'b000, 8'h00, 8'h00);
        chk(rd, 8'hc3);
        op(3'b001, 3'b000, 8'h81, 8'h00);
        chk(rd, 8'h00);
        op(3'b010, 3'b000, 8'h00, 8'h00);
        chk(rd, 8'hc3);
        chk(ptr, 8'hff);
        $display("test pointer wrap done");
        // Occupied addresses only, same address in both modes
        op(3'b001, 3'b110, 8'h90, 8'h5c);
        op(3'b001, 3'b100, 8'h90, 8'h11);
        op(3'b001, 3'b010, 8'h90, 8'h00);
        chk(rd, 8'h5c);
        op(3'b001, 3'b101, 8'h93, 8'h01);
        op(3'b001, 3'b000, 8'h90, 8'h00);
        chk(rd, 8'h19);
        op(3'b001, 3'b001, 8'h94, 8'h00);
        chk(rd, 8'h01);
        op(3'b001, 3'b100, 8'h22, 8'h00);
        op(3'b001, 3'b101, 8'h13, 8'h01);
        op(3'b001, 3'b000, 8'h22, 8'h00);
        chk(rd, 8'h08);
        $display("test special space done");
        op(3'b110, 3'b000, 8'h00, 8'h00);
        chk({7'h00, er}, 8'h01);
        chk(ptr, 8'hff);
        op(3'b001, 3'b011, 8'h10, 8'h01);
        chk({7'h00, er}, 8'h01);
        @(posedge clk);
        ce <= 1'b0;
        op(3'b100, 3'b000, 8'h00, 8'h77);
        chk(ptr, 8'hff);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(ptr, 8'h07);
        op(3'b100, 3'b000, 8'h00, 8'hd4);
        op(3'b001, 3'b000, 8'h08, 8'h00);
        chk(rd, 8'hd4);
        $display("test refusal and reset done");
        final_report();
    end
endmodule
bind ssp_sfr_stack ssp_sfr_stack_asserts u_chk (.i_ref_clk, .i_rst, .i_ce,
    .i_push, .i_push_data, .i_pop, .i_req, .o_rdata, .o_rvalid, .o_err,
    .o_stack_top_pointer, .o_ext, .i_ext_rdata);
`default_nettype wire

/* File: tb/ssp_periph_model.sv */
/* Peripheral special registers behind the forwarding port.
   Assumes reads are answered in the same cycle. */
`default_nettype none
module ssp_periph_model
    import ssp_pkg::*;
(
    // Clock and forwarded access
    input  wire logic     i_ref_clk,
    input  wire ssp_ext_t i_ext,
    // Read byte back
    output logic    [7:0] o_rdata
);
    logic [7:0] regs [256];
    logic [7:0] idle_r = 8'h5a;
    // Byte or single-bit write; idle data flips each cycle
    always_ff @(posedge i_ref_clk) begin
        idle_r <= ~idle_r;
        if (i_ext.valid && i_ext.write && i_ext.bit_mode)
            regs[i_ext.addr][i_ext.bit_pos] <= i_ext.wdata[0];
        else if (i_ext.valid && i_ext.write)
            regs[i_ext.addr] <= i_ext.wdata;
    end
    assign o_rdata = (i_ext.valid && !i_ext.write) ? regs[i_ext.addr] : idle_r;
endmodule
`default_nettype wire

/* File: tb/ssp_sfr_stack_asserts.sv */
/* Port checker for ssp_sfr_stack.
   Assumes one clock, reset synchronous and active high. */
`default_nettype none
module ssp_sfr_stack_asserts
    import ssp_pkg::*;
(
    // Clock and core side
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       i_ce,
    input wire logic       i_push,
    input wire logic [7:0] i_push_data,
    input wire logic       i_pop,
    input wire ssp_req_t   i_req,
    // Answers and peripheral side
    input wire logic [7:0] o_rdata,
    input wire logic       o_rvalid,
    input wire logic       o_err,
    input wire logic [7:0] o_stack_top_pointer,
    input wire ssp_ext_t   o_ext,
    input wire logic [7:0] i_ext_rdata
);
    logic [7:0] ptr;
    logic       one;
    logic       dir;
    // Exactly one request taken; direct byte access
    assign ptr = o_stack_top_pointer;
    assign one = i_ce && $onehot({i_push, i_pop, i_req.valid});
    assign dir = one && i_req.valid && !i_req.indirect && !i_req.bit_mode;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    property p_push;
        one && i_push |=> ptr == $past(ptr) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push pointer");
    property p_pop;
        one && i_pop |=> o_rvalid && ptr == $past(ptr) - 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop pointer");
    property p_rst;
        disable iff (1'b0) $fell(i_rst) |-> ptr == 8'h07;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pointer");
    property p_rd_ptr; dir && !i_req.write && i_req.addr == 8'h81
        |=> o_rvalid && o_rdata == $past(ptr); endproperty
    a_rd_ptr: assert property (p_rd_ptr) else $error("pointer read");
    property p_wr_ptr; dir && i_req.write && i_req.addr == 8'h81
        |=> ptr == $past(i_req.wdata); endproperty
    a_wr_ptr: assert property (p_wr_ptr) else $error("pointer write");
    property p_fwd; dir && i_req.addr[7] && i_req.addr != 8'h81
        |-> o_ext.valid && o_ext.addr == i_req.addr; endproperty
    a_fwd: assert property (p_fwd) else $error("special forward");
    property p_ind;
        one && i_req.valid && i_req.indirect |-> !o_ext.valid;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect leak");
    property p_bit; one && i_req.valid && !i_req.indirect && i_req.bit_mode
        && i_req.addr[7] |-> o_ext.addr == {i_req.addr[7:3], 3'h0}
        && o_ext.bit_pos == i_req.addr[2:0]; endproperty
    a_bit: assert property (p_bit) else $error("bit forward");
    c_push: cover property (one && i_push);
    c_pop: cover property (one && i_pop);
    c_bit: cover property (one && i_req.valid && i_req.bit_mode);
endmodule
`default_nettype wire

/* File: verilog/ssp_data_ram.sv */
/*
 * Internal data memory of 256 bytes held in flip-flops, one write port
 * and one combinational read port.
 * Assumes the owner resolves address modes; this store only sees bytes.
 */
`default_nettype none

module ssp_data_ram (
    // Clock and control
    input  wire logic       i_ref_clk,
    input  wire logic       i_ce,
    // Write port
    input  wire logic       i_we,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    // Read port, same address
    output logic      [7:0] o_rdata
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [SSP_RAM_DEPTH-1:0][7:0] mem;
    } ssp_ram_st_t;

    ssp_ram_st_t st_r;
    ssp_ram_st_t st_nxt;

    // Byte update at the addressed entry
    always_comb begin
        st_nxt = st_r;
        if (i_we) begin
            st_nxt.mem[i_addr] = i_wdata;
        end
    end

    // Contents are not cleared by reset
    always_ff @(posedge i_ref_clk) begin
        if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.mem[i_addr];

endmodule

`default_nettype wire

/* File: verilog/ssp_pkg.sv */
/*
 * Shared constants and carrier types for the special register space and
 * stack pointer block.
 * Assumes one core clock domain and a core that issues at most one
 * operation per enabled cycle.
 */
`default_nettype none

package ssp_pkg;

    // Address map
    localparam logic [7:0] SSP_SPECIAL_BASE = 8'h80; // Direct at/above: special
    localparam logic [7:0] SSP_STACK_ADDR   = 8'h81; // stack_top_pointer
    localparam logic [7:0] SSP_STACK_RESET  = 8'h07; // First push lands at 0x08
    localparam logic [3:0] SSP_BIT_RAM_HI   = 4'h2;  // Bit bytes 0x20..0x2f
    localparam int         SSP_RAM_DEPTH    = 256;   // Internal data memory

    // Operation request from the core's execution logic
    typedef struct packed {
        logic       valid;    // Request this cycle
        logic       write;    // 1 write, 0 read
        logic       indirect; // Indirect addressing mode
        logic       bit_mode; // Single-bit access, addr is a bit address
        logic [7:0] addr;     // Byte address, or bit address in bit mode
        logic [7:0] wdata;    // Write byte; bit value in wdata[0]
    } ssp_req_t;

    // Special register access forwarded to peripheral registers
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       bit_mode;
        logic [7:0] addr;     // Byte address of the special register
        logic [2:0] bit_pos;
        logic [7:0] wdata;
    } ssp_ext_t;

endpackage

`default_nettype wire

/* File: verilog/ssp_sfr_stack.sv */
/*
 * Special register space steering and hardware stack pointer.
 * Direct accesses at 0x80 and above go to special registers; the stack
 * pointer lives here, the rest are forwarded on the peripheral port.
 * Assumes peripheral read data returns combinationally in the same cycle
 * and that the core issues one operation per enabled cycle.
 */
`default_nettype none


// Operation overview
// Every enabled cycle the core may present one of three things: a push,
// a pop or an addressed access. Two or more at once are refused as a
// whole and raise the error pulse, so no priority scheme has to be
// agreed with the core and no half-done operation can occur.
//
// Push: the byte is stored one above the pointer and the pointer moves
// up in the same edge, so after the edge it names the byte just stored.
// Pop: the byte under the pointer is returned one cycle later and the
// pointer moves down in the same edge. A push followed directly by a pop
// therefore returns the pushed byte.
//
// Both directions wrap modulo 256. There is no overflow or underflow
// flag; software owns the stack depth. Placing the stack over the bank
// registers is legal and silently overwrites them.
//
// Addressed access: the addressing mode picks the target above 0x7f.
// Direct accesses there are special registers; the pointer is served
// locally and all other addresses, occupied or not, are forwarded on the
// peripheral port. Indirect accesses there reach the upper half of the
// data memory and never touch the peripheral port.
//
// Bit access: a bit address at or above 0x80 selects the special
// register whose address ends in 0 or 8 and a bit within it. A bit
// address below 0x80 selects one of the sixteen bytes from 0x20 up.
// Bit stores into data memory are a read-modify-write within one cycle.
// The pointer itself sits at an address that no bit address reaches.
//
// Timing: read data and its valid pulse are registered, one cycle after
// the request. The peripheral port is combinational and its read data
// must settle within the same cycle. Enable low freezes the pointer, the
// answer registers and the data memory, so a pulse stays high while
// the enable is low.
//
// Hazard: the data memory is not cleared by reset. Reading a location
// that was never written returns an unknown byte.

module ssp_sfr_stack (
    // Clock, reset, enable
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    // Stack operations from the core
    input  wire logic             i_push,
    input  wire logic       [7:0] i_push_data,
    input  wire logic             i_pop,
    // Memory and special register accesses from the core
    input  wire ssp_pkg::ssp_req_t i_req,
    // Answer to the core
    output logic            [7:0] o_rdata,
    output logic                  o_rvalid,
    output logic                  o_err,
    output logic            [7:0] o_stack_top_pointer,
    // Peripheral special register port
    output var ssp_pkg::ssp_ext_t o_ext,
    input  wire logic       [7:0] i_ext_rdata
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] rdata;
        logic       rvalid;
        logic       err;
    } ssp_st_t;

    ssp_st_t    st_r;
    ssp_st_t    st_nxt;
    logic       ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic [7:0] tgt;
    logic [2:0] pos;
    logic       to_special;
    logic [7:0] merged;
    logic [1:0] n_ops;

    // Read-modify-write byte for a single-bit store into data memory
    for (genvar b = 0; b < 8; b++) begin : g_merge
        assign merged[b] = (pos == 3'(b)) ? i_req.wdata[0] : ram_rdata[b];
    end

    // Bit address decode: 0x80 and up pick the register at nibble 0 or 8,
    // below 0x80 pick a byte of 0x20..0x2f
    always_comb begin
        pos = i_req.addr[2:0];
        if (!i_req.bit_mode) begin
            tgt = i_req.addr;
        end else if (i_req.addr[7]) begin
            tgt = {i_req.addr[7:3], 3'b000};
        end else begin
            tgt = {SSP_BIT_RAM_HI, i_req.addr[6:3]};
        end
        to_special = !i_req.indirect && (tgt >= SSP_SPECIAL_BASE);
        n_ops  = 2'(i_push) + 2'(i_pop) + 2'(i_req.valid);
    end

    // Operation sequencing and stack pointer update
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.err    = 1'b0;
        ram_we        = 1'b0;
        ram_addr      = st_r.ptr;
        ram_wdata     = i_push_data;
        o_ext         = '0;
        if (n_ops > 2'd1) begin
            st_nxt.err = 1'b1; // Colliding requests are dropped
        end else if (i_push) begin
            ram_addr   = st_r.ptr + 8'h01;
            ram_we     = 1'b1;
            st_nxt.ptr = st_r.ptr + 8'h01;
        end else if (i_pop) begin
            ram_addr      = st_r.ptr;
            st_nxt.rdata  = ram_rdata;
            st_nxt.rvalid = 1'b1;
            st_nxt.ptr    = st_r.ptr - 8'h01;
        end else if (i_req.valid) begin
            if (i_req.indirect && i_req.bit_mode) begin
                st_nxt.err = 1'b1; // No indirect bit mode exists
            end else if (to_special && tgt == SSP_STACK_ADDR) begin
                // Stack pointer is byte-only at its address
                if (i_req.write) begin
                    st_nxt.ptr = i_req.wdata;
                end else begin
                    st_nxt.rdata  = st_r.ptr;
                    st_nxt.rvalid = 1'b1;
                end
            end else if (to_special) begin
                // Other special registers are served by the peripherals
                o_ext.valid    = 1'b1;
                o_ext.write    = i_req.write;
                o_ext.bit_mode = i_req.bit_mode;
                o_ext.addr     = tgt;
                o_ext.bit_pos  = pos;
                o_ext.wdata    = i_req.wdata;
                if (!i_req.write) begin
                    st_nxt.rdata  = i_req.bit_mode ?
                                    {7'h00, i_ext_rdata[pos]} : i_ext_rdata;
                    st_nxt.rvalid = 1'b1;
                end
            end else begin
                // Data memory, lower or upper half
                ram_addr = tgt;
                if (i_req.write) begin
                    ram_we    = 1'b1;
                    ram_wdata = i_req.bit_mode ? merged : i_req.wdata;
                end else begin
                    st_nxt.rdata  = i_req.bit_mode ?
                                    {7'h00, ram_rdata[pos]} : ram_rdata;
                    st_nxt.rvalid = 1'b1;
                end
            end
        end
    end

    // State register; reset loads even with enable low, otherwise enable low freezes everything
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_r.ptr    <= SSP_STACK_RESET;
            st_r.rdata  <= 8'h00;
            st_r.rvalid <= 1'b0;
            st_r.err    <= 1'b0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // Internal data memory
    ssp_data_ram u_ram (
        .i_ref_clk (i_ref_clk),
        .i_ce      (i_ce && !i_rst),
        .i_we      (ram_we),
        .i_addr    (ram_addr),
        .i_wdata   (ram_wdata),
        .o_rdata   (ram_rdata)
    );

    assign o_rdata             = st_r.rdata;
    assign o_rvalid            = st_r.rvalid;
    assign o_err               = st_r.err;
    assign o_stack_top_pointer = st_r.ptr;

endmodule

`default_nettype wire
